//--- rtl/pcisi_defs.svh
// Constants for the bus signal interface: command codes, widths, clock rates, memory size
`ifndef PCISI_DEFS_SVH
`define PCISI_DEFS_SVH
`define PCISI_AD_W        32
`define PCISI_CBE_W       4
`define PCISI_CMD_INTACK  4'h0
`define PCISI_CMD_SPECIAL 4'h1
`define PCISI_CMD_MEMRD   4'h6
`define PCISI_CMD_MEMWR   4'h7
`define PCISI_CMD_CFGRD   4'ha
`define PCISI_CMD_CFGWR   4'hb
`define PCISI_CMD_MEMRDM  4'hc
`define PCISI_CMD_DAC     4'hd
`define PCISI_CMD_MEMRDL  4'he
`define PCISI_CMD_MEMWI   4'hf
`define PCISI_CLK_MHZ     25
`define PCISI_MAX_MHZ     66
`define PCISI_MEM_WORDS   16
`endif

//--- rtl/pcisi_pkg.sv
// Types shared by the bus signal interface
package pcisi_pkg;
  // Decoded command classes
  typedef enum logic [2:0] {
    PCISI_K_NONE, PCISI_K_MEMRD, PCISI_K_MEMWR, PCISI_K_CFGRD, PCISI_K_CFGWR
  } pcisi_kind_e;
  // Transaction phase machine
  typedef enum logic [2:0] {
    PCISI_S_IDLE, PCISI_S_DAC, PCISI_S_DATA, PCISI_S_SKIP, PCISI_S_TURN
  } pcisi_state_e;
endpackage : pcisi_pkg

//--- rtl/pcisi_mem.sv
// Small byte-writable word memory with registered read data
`timescale 1ns/100ps
`default_nettype none
module pcisi_mem #(
  parameter int AW = 4,
  parameter int DW = 32
) (
  input  wire logic          i_mclk,
  input  wire logic          i_we,
  input  wire logic [DW/8-1:0] i_be,
  input  wire logic [AW-1:0] i_addr,
  input  wire logic [DW-1:0] i_wdata,
  output logic      [DW-1:0] o_rdata
);
  // Refuse widths that do not split into whole byte lanes
  if (DW < 8 || (DW % 8) != 0 || AW < 1) begin : g_bad_width
    $error("data width must be whole bytes, address at least one bit");
  end

  // One storage array per byte lane, so each lane has a single writer
  for (genvar b = 0; b < DW/8; b++) begin : g_lane
    logic [7:0] lane_mem [0:(1<<AW)-1]; // Bytes of this lane

    // Lane write where its enable is set
    always_ff @(posedge i_mclk) begin
      if (i_we && i_be[b]) begin
        lane_mem[i_addr] <= i_wdata[b*8 +: 8];
      end
    end

    // Registered read of this lane
    always_ff @(posedge i_mclk) begin
      o_rdata[b*8 +: 8] <= lane_mem[i_addr];
    end
  end
endmodule : pcisi_mem
`default_nettype wire

//--- rtl/pcisi_parity.sv
// Even parity generator over address/data and command/byte-enable lines
`timescale 1ns/100ps
`default_nettype none
module pcisi_parity (
  input  wire logic        i_mclk,
  input  wire logic        i_rst_n,
  input  wire logic [31:0] i_ad,
  input  wire logic [3:0]  i_cbe_n,
  output logic             o_par
);
  // One clock behind the lines it covers
  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_par <= 1'b0;
    end else begin
      o_par <= ^{i_ad, i_cbe_n}; // [RL13]
    end
  end
endmodule : pcisi_parity
`default_nettype wire

//--- rtl/pcisi_target.sv
// Bus target: address/data and command decode onto a small word memory
//
// Function
// [RL1] One address phase, then one or more data phases
// [RL2] Shared 32-bit bus, low byte on lines 7:0
// [RL3] All bus signals sampled on rising clock
// [RL4] Works with bus clock up to 66 MHz
// [RL5] Bus reset returns every function to reset (input sample stages reset on board reset only, memory keeps its contents)
// [RL6] Command in address phase, byte enables in data
// [RL7] 0000 interrupt acknowledge, 0001 special cycle
// [RL8] 0110 memory read, 0111 memory write
// [RL9] 1010 configuration read, 1011 configuration write
// [RL10] 1100 read multiple, 1110 read line
// [RL11] 1101 dual address cycle, two address phases
// [RL12] 1111 memory write and invalidate
// [RL13] Even parity over bus, one clock later
// [RL14] Host selects device for configuration cycles
// [RL15] Unsupported commands are not claimed
`timescale 1ns/100ps
`default_nettype none
`include "pcisi_defs.svh"
module pcisi_target
  import pcisi_pkg::*;
#(
  parameter int MEM_WORDS = `PCISI_MEM_WORDS,
  parameter int CLK_MHZ   = `PCISI_CLK_MHZ
) (
  input  wire logic        i_mclk,
  input  wire logic        i_rst_n,
  input  wire logic        i_bus_reset_n,
  input  wire logic [31:0] i_ad,
  input  wire logic [3:0]  i_cbe_n,
  input  wire logic        i_frame_n,
  input  wire logic        i_irdy_n,
  input  wire logic        i_idsel,
  output logic      [31:0] o_ad,
  output logic             o_ad_oe_n,
  output logic             o_par,
  output logic             o_par_oe_n,
  output logic             o_devsel_n,
  output logic             o_trdy_n,
  output logic             o_tgt_oe_n,
  output logic             o_busy
);
  localparam int AW = $clog2(MEM_WORDS);

  // ****************************************
  // Elaboration checks
  // ****************************************
  if (CLK_MHZ > `PCISI_MAX_MHZ) begin : g_bad_clk
    $error("clock above supported bus rate"); // [RL4]
  end
  if (MEM_WORDS < 2 || (1 << AW) != MEM_WORDS) begin : g_bad_mem
    $error("memory words must be a power of two, at least two");
  end

  // ****************************************
  // Reset release and input synchronisers
  // ****************************************
  logic [1:0]  rst_sync;      // Reset release chain
  logic        rst_n;         // Released reset
  logic [1:0]  bres_sync;     // Bus reset chain
  logic [31:0] ad_s1, ad_s;   // Address/data stages
  logic [3:0]  cbe_s1, cbe_s; // Command/byte-enable stages
  logic [2:0]  ctl_s1, ctl_s; // Frame, ready, select stages

  // Reset combines board reset and bus reset
  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      rst_sync <= 2'h0;
    end else begin
      rst_sync <= {rst_sync[0], bres_sync[1]}; // [RL5]
    end
  end
  assign rst_n = rst_sync[1];

  // Bus reset passes two flops
  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      bres_sync <= 2'h0;
    end else begin
      bres_sync <= {bres_sync[0], i_bus_reset_n};
    end
  end

  // Bus lines sampled on rising edge, two stages
  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      ad_s1  <= 32'h0;
      ad_s   <= 32'h0;
      cbe_s1 <= 4'hf;
      cbe_s  <= 4'hf;
      ctl_s1 <= 3'h3;
      ctl_s  <= 3'h3;
    end else begin
      ad_s1  <= i_ad; // [RL3]
      ad_s   <= ad_s1;
      cbe_s1 <= i_cbe_n;
      cbe_s  <= cbe_s1;
      ctl_s1 <= {i_idsel, i_irdy_n, i_frame_n};
      ctl_s  <= ctl_s1;
    end
  end

  // Named views of the synchronised control lines
  logic frame_n;   // Frame low while transaction lasts
  logic irdy_n;    // Initiator ready
  logic idsel;     // Configuration select
  logic frame_q;   // Frame seen previous cycle
  assign frame_n = ctl_s[0];
  assign irdy_n  = ctl_s[1];
  assign idsel   = ctl_s[2];

  // ****************************************
  // Command decode
  // ****************************************
  pcisi_kind_e kind; // Class of command on the bus
  logic        dac;  // Dual address cycle pending

  // Map command code to a class, unclaimed codes give none
  always_comb begin
    kind = PCISI_K_NONE;
    dac  = 1'b0;
    unique case (cbe_s) // [RL6]
      `PCISI_CMD_INTACK, `PCISI_CMD_SPECIAL: kind = PCISI_K_NONE; // [RL7]
      `PCISI_CMD_MEMRD, `PCISI_CMD_MEMRDM, `PCISI_CMD_MEMRDL: begin
        kind = PCISI_K_MEMRD; // [RL8] [RL10]
      end
      `PCISI_CMD_MEMWR, `PCISI_CMD_MEMWI: begin
        kind = PCISI_K_MEMWR; // [RL8] [RL12]
      end
      `PCISI_CMD_CFGRD: kind = idsel ? PCISI_K_CFGRD : PCISI_K_NONE; // [RL9] [RL14]
      `PCISI_CMD_CFGWR: kind = idsel ? PCISI_K_CFGWR : PCISI_K_NONE; // [RL9] [RL14]
      `PCISI_CMD_DAC: dac = 1'b1; // [RL11]
      default: kind = PCISI_K_NONE; // [RL15]
    endcase
  end

  // ****************************************
  // Phase machine
  // ****************************************
  pcisi_state_e state;   // Current phase
  pcisi_kind_e  cur;     // Claimed command class
  logic [AW-1:0] addr;   // Word address of current data phase
  logic          rd;     // Claimed transaction is a read
  logic          start;  // Address phase: frame falls

  // Frame history for edge detection
  always_ff @(posedge i_mclk or negedge rst_n) begin
    if (!rst_n) begin
      frame_q <= 1'b1;
    end else begin
      frame_q <= frame_n;
    end
  end
  assign start = frame_q && !frame_n; // [RL1]

  // State, class and address tracking
  always_ff @(posedge i_mclk or negedge rst_n) begin
    if (!rst_n) begin
      state <= PCISI_S_IDLE;
      cur   <= PCISI_K_NONE;
      addr  <= '0;
    end else begin
      unique case (state)
        PCISI_S_IDLE: begin
          if (start && dac) begin
            state <= PCISI_S_DAC; // [RL11]
          end else if (start && kind != PCISI_K_NONE) begin
            state <= PCISI_S_DATA; // [RL1]
            cur   <= kind;
            addr  <= ad_s[AW+1:2]; // [RL2]
          end else if (start) begin
            state <= PCISI_S_SKIP; // [RL15]
          end
        end
        PCISI_S_DAC: begin
          // Second address phase is above 4 GiB: never ours
          state <= PCISI_S_SKIP; // [RL11]
        end
        PCISI_S_DATA: begin
          if (!irdy_n) begin
            addr <= addr + 1'b1; // Burst advance
            if (frame_n) begin
              state <= PCISI_S_TURN; // Last data phase
            end
          end
        end
        PCISI_S_SKIP: begin
          if (frame_n && !irdy_n) begin
            state <= PCISI_S_IDLE;
          end else if (frame_n && irdy_n) begin
            state <= PCISI_S_IDLE;
          end
        end
        PCISI_S_TURN: begin
          state <= PCISI_S_IDLE; // Turnaround cycle
          cur   <= PCISI_K_NONE;
        end
        // Unused state codes fall back to idle
        default: begin
          state <= PCISI_S_IDLE;
          cur   <= PCISI_K_NONE;
        end
      endcase
    end
  end
  assign rd = (cur == PCISI_K_MEMRD) || (cur == PCISI_K_CFGRD);

  // ****************************************
  // Storage
  // ****************************************
  logic        mem_we;    // Write strobe for a data phase
  logic [31:0] mem_rdata; // Registered read word
  assign mem_we = (state == PCISI_S_DATA) && !rd && !irdy_n;

  pcisi_mem #(
    .AW (AW),
    .DW (32)
  ) u_mem (
    .i_mclk  (i_mclk),
    .i_we    (mem_we),
    .i_be    (~cbe_s), // [RL6]
    .i_addr  (addr),
    .i_wdata (ad_s),
    .o_rdata (mem_rdata)
  );

  // ****************************************
  // Outputs
  // ****************************************
  logic claimed; // Device owns current transaction
  assign claimed = (state == PCISI_S_DATA);

  // Target control and read data drive
  always_ff @(posedge i_mclk or negedge rst_n) begin
    if (!rst_n) begin
      o_ad       <= 32'h0;
      o_ad_oe_n  <= 1'b1;
      o_devsel_n <= 1'b1;
      o_trdy_n   <= 1'b1;
      o_tgt_oe_n <= 1'b1;
      o_busy     <= 1'b0;
    end else begin
      o_ad       <= mem_rdata; // [RL2]
      o_ad_oe_n  <= !(claimed && rd);
      o_devsel_n <= !claimed;
      o_trdy_n   <= !claimed;
      o_tgt_oe_n <= !(claimed || state == PCISI_S_TURN);
      o_busy     <= (state != PCISI_S_IDLE);
    end
  end

  // Parity drive enable follows read data by one clock
  always_ff @(posedge i_mclk or negedge rst_n) begin
    if (!rst_n) begin
      o_par_oe_n <= 1'b1;
    end else begin
      o_par_oe_n <= o_ad_oe_n; // [RL13]
    end
  end

  // Parity over driven data and the sampled byte enables
  pcisi_parity u_par (
    .i_mclk  (i_mclk),
    .i_rst_n (rst_n),
    .i_ad    (o_ad),
    .i_cbe_n (cbe_s),
    .o_par   (o_par)
  );
endmodule : pcisi_target
`default_nettype wire

//--- testbench/pcisi_target_asserts.sv
// Checker for the bus target ports
`timescale 1ns/100ps
`default_nettype none
module pcisi_target_asserts (
  input wire logic        i_mclk,
  input wire logic        i_rst_n,
  input wire logic        i_bus_reset_n,
  input wire logic [3:0]  i_cbe_n,
  input wire logic        i_frame_n,
  input wire logic        i_idsel,
  input wire logic [31:0] o_ad,
  input wire logic        o_ad_oe_n,
  input wire logic        o_par,
  input wire logic        o_par_oe_n,
  input wire logic        o_devsel_n,
  input wire logic        o_tgt_oe_n,
  input wire logic        o_busy
);
  // ****
  // Supported command decode
  // ****
  logic ok;
  assign ok = (i_cbe_n inside {4'h6, 4'h7, 4'hc, 4'he, 4'hf}) || (i_idsel && i_cbe_n[3:1] == 3'h5);
  default clocking @(posedge i_mclk); endclocking
  default disable iff (!i_rst_n);
  property p_claim; $fell(i_frame_n) && ok |-> ##[2:8] !o_devsel_n; endproperty
  a_claim: assert property (p_claim) else $error("claim missing");
  property p_skip; $fell(i_frame_n) && !ok |=> o_devsel_n [*8]; endproperty
  a_skip: assert property (p_skip) else $error("bad claim");
  property p_dac; $fell(i_frame_n) && i_cbe_n == 4'hd |=> o_tgt_oe_n [*8]; endproperty
  a_dac: assert property (p_dac) else $error("dual cycle claimed");
  property p_cfg;
    $fell(i_frame_n) && i_cbe_n[3:1] == 3'h5 && !i_idsel |=> o_tgt_oe_n [*8];
  endproperty
  a_cfg: assert property (p_cfg) else $error("config without select");
  property p_wr; $fell(i_frame_n) && i_cbe_n == 4'h7 |=> o_ad_oe_n [*8]; endproperty
  a_wr: assert property (p_wr) else $error("write drove bus");
  property p_rd;
    $fell(i_frame_n) && (i_cbe_n inside {4'h6, 4'hc, 4'he}) |-> ##[2:8] !o_ad_oe_n;
  endproperty
  a_rd: assert property (p_rd) else $error("read not driven");
  property p_par_oe; $fell(o_ad_oe_n) |=> $fell(o_par_oe_n); endproperty
  a_par_oe: assert property (p_par_oe) else $error("parity enable lag");
  property p_par;
    !o_par_oe_n && !$past(o_ad_oe_n) && $past(i_cbe_n, 3) == 4'h0 |-> o_par == ^$past(o_ad);
  endproperty
  a_par: assert property (p_par) else $error("parity wrong");
  property p_rst;
    !i_bus_reset_n [*6] |-> o_tgt_oe_n && o_ad_oe_n && o_par_oe_n && !o_busy;
  endproperty
  a_rst: assert property (p_rst) else $error("bus reset ignored");
  property p_oe; !o_devsel_n |-> !o_tgt_oe_n; endproperty
  a_oe: assert property (p_oe) else $error("claim not driven");
  c_wr: cover property ($fell(i_frame_n) && i_cbe_n == 4'h7 ##[2:8] !o_devsel_n);
  c_rd: cover property ($fell(i_frame_n) && i_cbe_n == 4'h6 ##[2:8] !o_ad_oe_n);
  c_abort: cover property (!i_bus_reset_n && o_busy);
endmodule : pcisi_target_asserts
bind pcisi_target pcisi_target_asserts i_chk (.i_mclk(i_mclk), .i_rst_n(i_rst_n),
  .i_bus_reset_n(i_bus_reset_n), .i_cbe_n(i_cbe_n), .i_frame_n(i_frame_n),
  .i_idsel(i_idsel), .o_ad(o_ad), .o_ad_oe_n(o_ad_oe_n), .o_par(o_par),
  .o_par_oe_n(o_par_oe_n), .o_devsel_n(o_devsel_n), .o_tgt_oe_n(o_tgt_oe_n), .o_busy(o_busy));
`default_nettype wire

//--- testbench/pcisi_master.sv
// Bus initiator model facing the target
`timescale 1ns/100ps
`default_nettype none
module pcisi_master (
  input  wire logic        i_mclk,
  input  wire logic [31:0] i_bus,
  input  wire logic        i_trdy_n,
  output var  logic [31:0] o_ad,
  output var  logic [3:0]  o_cbe_n,
  output var  logic        o_frame_n,
  output var  logic        o_irdy_n,
  output var  logic        o_idsel
);
  initial {o_ad, o_cbe_n, o_frame_n, o_irdy_n, o_idsel} = {32'h0, 4'hf, 3'b110};
  // Move just after the rising edge
  task automatic tick;
    @(posedge i_mclk);
    #1;
  endtask : tick
  // Address phase, wait for ready, then n data phases
  task automatic xfer(input logic [3:0] cmd, input logic sel, input logic [31:0] adr,
      input logic [3:0] be, input logic [31:0] w0, input logic [31:0] w1, input int n,
      output logic hit, output logic [31:0] rd);
    logic wr;
    wr = cmd[0];
    hit = 1'b0;
    rd = '0;
    {o_ad, o_cbe_n, o_frame_n, o_idsel} = {adr, cmd, 1'b0, sel};
    tick;
    {o_ad, o_cbe_n, o_idsel} = {wr ? w0 : ~adr, be, 1'b0};
    for (int k = 0; k < 10 && !hit; k++) begin
      @(posedge i_mclk);
      hit = !i_trdy_n;
    end
    #1;
    for (int i = 0; i < n && hit; i++) begin
      {o_ad, o_frame_n, o_irdy_n} = {wr ? (i == 0 ? w0 : w1) : ~o_ad, i == n - 1, 1'b0};
      @(posedge i_mclk);
      rd = i_bus;
      #1;
    end
    // Release: pulled-up controls high, data parked off its last value
    {o_ad, o_cbe_n, o_frame_n, o_irdy_n} = {~o_ad, ~o_cbe_n, 2'b11};
  endtask : xfer
endmodule : pcisi_master
`default_nettype wire

//--- testbench/tb_pci_bus_signal_interface.sv
// Self-checking bench for the bus target
`timescale 1ns/100ps
`default_nettype none
module tb_pci_bus_signal_interface;
  logic        i_mclk, i_rst_n, i_bus_reset_n, m_frame_n, m_irdy_n, m_idsel, hit;
  logic        o_ad_oe_n, o_par, o_par_oe_n, o_devsel_n, o_trdy_n, o_tgt_oe_n, o_busy;
  logic [3:0]  m_cbe_n;
  logic [31:0] m_ad, bus, o_ad, rd, wd;
  logic [31:0] exp_mem [16];
  // Rows: command, claim, select, byte address
  logic [15:0] rows [14] = '{16'h7204, 16'h6204, 16'hf208, 16'hc208, 16'hb30c, 16'hb00c,
    16'he20c, 16'ha304, 16'ha004, 16'h0000, 16'h1000, 16'hd000, 16'h2000, 16'h9000};
  int          n_fail = 0, compares = 0, cyc = 0;
  assign bus = o_ad_oe_n ? m_ad : o_ad;
  pcisi_target i_dut (.i_mclk(i_mclk), .i_rst_n(i_rst_n), .i_bus_reset_n(i_bus_reset_n),
    .i_ad(bus), .i_cbe_n(m_cbe_n), .i_frame_n(m_frame_n), .i_irdy_n(m_irdy_n),
    .i_idsel(m_idsel), .o_ad(o_ad), .o_ad_oe_n(o_ad_oe_n), .o_par(o_par),
    .o_par_oe_n(o_par_oe_n), .o_devsel_n(o_devsel_n), .o_trdy_n(o_trdy_n),
    .o_tgt_oe_n(o_tgt_oe_n), .o_busy(o_busy));
  pcisi_master i_host (.i_mclk(i_mclk), .i_bus(bus), .i_trdy_n(o_trdy_n), .o_ad(m_ad),
    .o_cbe_n(m_cbe_n), .o_frame_n(m_frame_n), .o_irdy_n(m_irdy_n), .o_idsel(m_idsel));
  initial begin
    i_mclk = 1'b0;
    forever #20 i_mclk = ~i_mclk;
  end
  // Compare and count
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      n_fail++;
      $display("FAIL %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic idle(input int n);
    repeat (n) @(posedge i_mclk);
    #1;
  endtask : idle
  task automatic stop_test;
    $display("compares %0d n_fail %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : stop_test
  // Hang guard
  always @(posedge i_mclk) begin
    cyc++;
    if (cyc == 5000) begin
      n_fail++;
      stop_test;
    end
  end
  initial begin
    i_rst_n = 1'b0;
    i_bus_reset_n = 1'b0;
    idle(7);
    check("idle", {o_devsel_n, o_trdy_n, o_tgt_oe_n, o_ad_oe_n, o_par_oe_n, o_busy, o_par},
      7'h7c);
    check("reset ad", o_ad, 32'h0);
    idle(1);
    i_rst_n = 1'b1;
    i_bus_reset_n = 1'b1;
    idle(8);
    // Command table
    foreach (rows[r]) begin
      wd = {7'h52, rows[r][8], rows[r][7:0], rows[r][15:12], 12'h03c};
      i_host.xfer(rows[r][15:12], rows[r][8], {24'h0, rows[r][7:0]}, 4'h0, wd, wd, 1, hit, rd);
      check("claim", hit, rows[r][9]);
      if (hit && rows[r][12]) exp_mem[rows[r][5:2]] = wd;
      else if (hit) check("read", rd, exp_mem[rows[r][5:2]]);
      idle(6);
    end
    // Burst then a partial-lane write
    i_host.xfer(4'h7, 1'b0, 32'h20, 4'h0, 32'hffffffff, 32'h9abcdef0, 2, hit, rd);
    idle(6);
    i_host.xfer(4'h7, 1'b0, 32'h20, 4'ha, 32'h11223344, 32'h0, 1, hit, rd);
    idle(6);
    i_host.xfer(4'h6, 1'b0, 32'h20, 4'h0, 32'h0, 32'h0, 1, hit, rd);
    check("lanes", rd, 32'hff22ff44);
    idle(6);
    i_host.xfer(4'h6, 1'b0, 32'h24, 4'h0, 32'h0, 32'h0, 1, hit, rd);
    check("burst", rd, 32'h9abcdef0);
    idle(6);
    // Bus reset in mid-transaction
    fork
      i_host.xfer(4'h6, 1'b0, 32'h20, 4'h0, 32'h0, 32'h0, 1, hit, rd);
      begin
        idle(5);
        i_bus_reset_n = 1'b0;
        idle(6);
        check("bus reset", {o_devsel_n, o_tgt_oe_n, o_ad_oe_n, o_busy}, 4'he);
        i_bus_reset_n = 1'b1;
      end
    join
    idle(8);
    i_host.xfer(4'h6, 1'b0, 32'h24, 4'h0, 32'h0, 32'h0, 1, hit, rd);
    check("after reset", hit, 1'b1);
    idle(6);
    stop_test;
  end
endmodule : tb_pci_bus_signal_interface
`default_nettype wire
